// ### mtlb_core_model.sv
// Core pipeline model issuing logical addresses to the translator
module mtlb_core_model (
   input wire logic clk,
   output logic req_valid,
   output logic [31:0] req_addr,
   output logic req_write,
   output logic current_user_mode_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      req_valid = 1'b0;
      req_addr = 32'h0000_0000;
      req_write = 1'b0;
      current_user_mode_flag = 1'b0;
   end
   task automatic issue(input logic [31:0] a, input logic w, input logic u);
      @(negedge clk);
      req_valid = 1'b1;
      req_addr = a;
      req_write = w;
      current_user_mode_flag = u;
      @(negedge clk);
      // Inverse on release, so a stale address never looks held
      req_valid = 1'b0;
      req_addr = ~a;
      req_write = ~w;
   endtask
endmodule

// ### mtlb_pkg.sv
// Types shared by the address translation unit
package mtlb_pkg;
   typedef enum logic [2:0] {
      EXC_NONE = 3'b000,
      EXC_ADDR_ERROR = 3'b001,
      EXC_REFILL = 3'b010,
      EXC_INVALID = 3'b011,
      EXC_MODIFY = 3'b100,
      EXC_BUS_ERROR = 3'b101
   } mtlb_exc_e;
   typedef enum logic [1:0] {
      FLOOR_VM_OFF = 2'b00,
      FLOOR_RAM_END = 2'b01,
      FLOOR_KMAP = 2'b10,
      FLOOR_USER = 2'b11
   } mtlb_floor_e;
endpackage

// ### mtlb_regs.svh
// Constants for the address translation unit: field positions, bounds and selectors
`ifndef MTLB_REGS_SVH
`define MTLB_REGS_SVH
`define MTLB_PAGE_MSB 31
`define MTLB_PAGE_LSB 12
`define MTLB_OFFSET_MSB 11
`define MTLB_TAG_MSB 11
`define MTLB_TAG_LSB 6
`define MTLB_UNCACHED_BIT 11
`define MTLB_WRITE_EN_BIT 10
`define MTLB_VALID_BIT 9
`define MTLB_GLOBAL_BIT 8
`define MTLB_KMAP_BOUND 32'h4000_0000
`define MTLB_USER_BOUND 32'h8000_0000
`define MTLB_RAM_START 32'h2000_0000
`define MTLB_SEL_ENTRY_HIGH 2'h0
`define MTLB_SEL_ENTRY_LOW 2'h1
`define MTLB_SEL_FAULT_ADDR 2'h2
`define MTLB_SEL_FLOOR 2'h3
`define MTLB_ENTRY_RESET 64'h0000_0000_0000_0000
`define MTLB_WORD_RESET 32'h0000_0000
`define MTLB_MIN_ENTRIES 7'h04
`define MTLB_MAX_ENTRIES 7'h40
`endif

// ### mtlb_translator.sv
// Logical to physical address translation with a fully associative lookup table
`include "mtlb_regs.svh"

module mtlb_translator #(
   parameter int MAX_ENTRIES = 64
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] floor_select,
   input wire logic [6:0] entry_count,
   input wire logic [31:0] ram_base,
   input wire logic [31:0] ram_size,
   input wire logic req_valid,
   input wire logic [31:0] req_addr,
   input wire logic req_write,
   input wire logic current_user_mode_flag,
   input wire logic reg_wr_en,
   input wire logic [1:0] reg_sel,
   input wire logic [31:0] reg_wdata,
   input wire logic tlb_wr_en,
   input wire logic [5:0] tlb_wr_index,
   output logic resp_valid,
   output logic [31:0] resp_addr,
   output mtlb_pkg::mtlb_exc_e resp_exc,
   output logic [31:0] reg_rdata,
   output logic [31:0] floor_address,
   output logic cfg_ready
);

   logic [63:0] table_mem [MAX_ENTRIES];
   logic [31:0] entry_high_reg;
   logic [31:0] entry_low_reg;
   logic [31:0] faulting_address_reg;
   mtlb_pkg::mtlb_floor_e floor_mode;
   logic [6:0] active_count;
   logic [31:0] ram_end_address;

   // Config is caught once after reset release, then frozen
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ready <= 1'b0;
         floor_mode <= mtlb_pkg::FLOOR_VM_OFF;
         active_count <= `MTLB_MIN_ENTRIES;
      end else if (!cfg_ready) begin
         cfg_ready <= 1'b1;
         floor_mode <= mtlb_pkg::mtlb_floor_e'(floor_select);
         if (entry_count < `MTLB_MIN_ENTRIES) begin
            active_count <= `MTLB_MIN_ENTRIES;
         end else if (entry_count > `MTLB_MAX_ENTRIES) begin
            active_count <= `MTLB_MAX_ENTRIES;
         end else begin
            active_count <= entry_count;
         end
      end
   end

   always_comb begin
      ram_end_address = ram_base + ram_size;
   end

   logic [31:0] next_floor;
   always_comb begin
      case (floor_mode)
         mtlb_pkg::FLOOR_RAM_END: next_floor = ram_end_address;
         mtlb_pkg::FLOOR_KMAP: next_floor = `MTLB_KMAP_BOUND;
         mtlb_pkg::FLOOR_USER: next_floor = `MTLB_USER_BOUND;
         default: next_floor = 32'hffff_ffff;
      endcase
   end

   // Read-only view of the floor
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         floor_address <= `MTLB_WORD_RESET;
      end else begin
         floor_address <= next_floor;
      end
   end

   // Off mode never translates, even the top address
   logic translate;
   always_comb begin
      translate = (floor_mode != mtlb_pkg::FLOOR_VM_OFF) && (req_addr >= next_floor);
   end

   // Page and tag compare, shared by the lookup and its top-down cross-check
   function automatic logic slot_match(input logic [63:0] entry, input logic [31:0] addr, input logic [5:0] tag);
      slot_match = (entry[63:32+`MTLB_PAGE_LSB] == addr[`MTLB_PAGE_MSB:`MTLB_PAGE_LSB])
                   && (entry[`MTLB_GLOBAL_BIT] || entry[32+`MTLB_TAG_MSB:32+`MTLB_TAG_LSB] == tag);
   endfunction

   // Parallel compare; later slots override earlier ones
   logic hit;
   logic [63:0] hit_entry;
   always_comb begin
      hit = 1'b0;
      hit_entry = `MTLB_ENTRY_RESET;
      for (int i = 0; i < MAX_ENTRIES; i++) begin
         if ((7'(i) < active_count)
             && slot_match(table_mem[i], req_addr, entry_high_reg[`MTLB_TAG_MSB:`MTLB_TAG_LSB])) begin
            hit = 1'b1;
            hit_entry = table_mem[i];
         end
      end
   end

   // Top-down search stopping at the first hit, so a priority slip shows up
   logic top_hit;
   logic [5:0] top_index;
   always_comb begin
      top_hit = 1'b0;
      top_index = 6'h00;
      for (int i = MAX_ENTRIES - 1; i >= 0; i--) begin
         if (!top_hit && (7'(i) < active_count)
             && slot_match(table_mem[i], req_addr, entry_high_reg[`MTLB_TAG_MSB:`MTLB_TAG_LSB])) begin
            top_hit = 1'b1;
            top_index = 6'(i);
         end
      end
   end

   mtlb_pkg::mtlb_exc_e next_exc;
   logic [31:0] next_addr;
   logic load_fault;
   logic load_page;
   always_comb begin
      next_exc = mtlb_pkg::EXC_NONE;
      next_addr = req_addr;
      load_fault = 1'b0;
      load_page = 1'b0;
      if (translate) begin
         if (current_user_mode_flag && req_addr < `MTLB_USER_BOUND) begin
            next_exc = mtlb_pkg::EXC_ADDR_ERROR;
            load_fault = 1'b1;
         end else if (!hit) begin
            next_exc = mtlb_pkg::EXC_REFILL;
            load_fault = 1'b1;
            load_page = 1'b1;
         end else if (!hit_entry[`MTLB_VALID_BIT]) begin
            next_exc = mtlb_pkg::EXC_INVALID;
            load_fault = 1'b1;
            load_page = 1'b1;
         end else if (req_write && !hit_entry[`MTLB_WRITE_EN_BIT]) begin
            next_exc = mtlb_pkg::EXC_MODIFY;
            load_fault = 1'b1;
            load_page = 1'b1;
         end else begin
            // Uncached flag is ignored by design
            next_addr = {hit_entry[`MTLB_PAGE_MSB:`MTLB_PAGE_LSB],
                         req_addr[`MTLB_OFFSET_MSB:0]};
            if (next_addr >= ram_end_address) begin
               next_exc = mtlb_pkg::EXC_BUS_ERROR;
            end else if (next_addr < `MTLB_RAM_START && current_user_mode_flag) begin
               next_exc = mtlb_pkg::EXC_ADDR_ERROR;
            end
         end
      end
   end

   logic accept;
   always_comb begin
      accept = req_valid && cfg_ready;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resp_valid <= 1'b0;
         resp_addr <= `MTLB_WORD_RESET;
         resp_exc <= mtlb_pkg::EXC_NONE;
      end else begin
         resp_valid <= accept;
         if (accept) begin
            resp_addr <= next_addr;
            resp_exc <= next_exc;
         end
      end
   end

   // Fault address loads only on an accepted fault; software writes never reach it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         faulting_address_reg <= `MTLB_WORD_RESET;
      end else if (accept && load_fault) begin
         faulting_address_reg <= req_addr;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         entry_high_reg <= `MTLB_WORD_RESET;
      end else begin
         if (reg_wr_en && reg_sel == `MTLB_SEL_ENTRY_HIGH) begin
            entry_high_reg <= reg_wdata;
         end
         if (accept && load_page) begin
            entry_high_reg[`MTLB_PAGE_MSB:`MTLB_PAGE_LSB] <= req_addr[`MTLB_PAGE_MSB:`MTLB_PAGE_LSB];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         entry_low_reg <= `MTLB_WORD_RESET;
      end else if (reg_wr_en && reg_sel == `MTLB_SEL_ENTRY_LOW) begin
         entry_low_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `MTLB_WORD_RESET;
      end else begin
         case (reg_sel)
            `MTLB_SEL_ENTRY_HIGH: reg_rdata <= entry_high_reg;
            `MTLB_SEL_ENTRY_LOW: reg_rdata <= entry_low_reg;
            `MTLB_SEL_FAULT_ADDR: reg_rdata <= faulting_address_reg;
            default: reg_rdata <= floor_address;
         endcase
      end
   end

   // Slot load from the two staging registers; out-of-range slots ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < MAX_ENTRIES; i++) begin
            table_mem[i] <= `MTLB_ENTRY_RESET;
         end
      end else if (tlb_wr_en && {1'b0, tlb_wr_index} < active_count) begin
         table_mem[tlb_wr_index] <= {entry_high_reg, entry_low_reg};
      end
   end

   sequence s_take;
      req_valid && cfg_ready;
   endsequence

   sequence s_take_low;
      s_take and (!translate);
   endsequence

   // Translated, matched, valid and write-permitted: the join path
   sequence s_mapped_ok;
      req_valid && cfg_ready && translate && hit && hit_entry[`MTLB_VALID_BIT]
      && !(current_user_mode_flag && req_addr < `MTLB_USER_BOUND)
      && !(req_write && !hit_entry[`MTLB_WRITE_EN_BIT]);
   endsequence

   a_resp_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
      s_take |=> resp_valid)
      else $error("response not one cycle after request");

   a_floor_passthru: assert property (@(posedge clk) disable iff (!rst_n)
      s_take_low |=> resp_addr == $past(req_addr) && resp_exc == mtlb_pkg::EXC_NONE)
      else $error("address below floor was altered");

   a_off_never_maps: assert property (@(posedge clk) disable iff (!rst_n)
      s_take and (floor_mode == mtlb_pkg::FLOOR_VM_OFF) |=> resp_exc == mtlb_pkg::EXC_NONE)
      else $error("translation off yet exception raised");

   a_floor_frozen: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_ready |=> $stable(floor_mode) && $stable(active_count))
      else $error("floor or count changed while running");

   a_user_kernel: assert property (@(posedge clk) disable iff (!rst_n)
      s_take and (translate && current_user_mode_flag && req_addr < `MTLB_USER_BOUND)
      |=> resp_exc == mtlb_pkg::EXC_ADDR_ERROR && faulting_address_reg == $past(req_addr))
      else $error("user kernel access not refused");

   a_refill_load: assert property (@(posedge clk) disable iff (!rst_n)
      s_take and (next_exc == mtlb_pkg::EXC_REFILL)
      |=> faulting_address_reg == $past(req_addr)
          && entry_high_reg[31:12] == $past(req_addr[31:12]))
      else $error("refill did not load fault registers");

   a_invalid_first: assert property (@(posedge clk) disable iff (!rst_n)
      s_take and (translate && hit && !hit_entry[`MTLB_VALID_BIT]
                  && !(current_user_mode_flag && req_addr < `MTLB_USER_BOUND))
      |=> resp_exc == mtlb_pkg::EXC_INVALID)
      else $error("invalid entry not reported first");

   a_frame_join: assert property (@(posedge clk) disable iff (!rst_n)
      s_mapped_ok and ({hit_entry[31:12], req_addr[11:0]} < ram_end_address
                       && !(current_user_mode_flag && {hit_entry[31:12], req_addr[11:0]} < `MTLB_RAM_START))
      |=> resp_exc == mtlb_pkg::EXC_NONE && resp_addr == {$past(hit_entry[31:12]), $past(req_addr[11:0])})
      else $error("physical address not frame plus offset");

   a_bus_past_end: assert property (@(posedge clk) disable iff (!rst_n)
      s_mapped_ok and ({hit_entry[31:12], req_addr[11:0]} >= ram_end_address)
      |=> resp_exc == mtlb_pkg::EXC_BUS_ERROR)
      else $error("joined address past end not refused as bus error");

   a_resp_drops: assert property (@(posedge clk) disable iff (!rst_n)
      !(req_valid && cfg_ready) |=> !resp_valid)
      else $error("response without request");

   a_user_low_phys: assert property (@(posedge clk) disable iff (!rst_n)
      s_mapped_ok and (current_user_mode_flag && {hit_entry[31:12], req_addr[11:0]} < `MTLB_RAM_START
                       && {hit_entry[31:12], req_addr[11:0]} < ram_end_address)
      |=> resp_exc == mtlb_pkg::EXC_ADDR_ERROR)
      else $error("user access below RAM start not refused");

   a_write_protect: assert property (@(posedge clk) disable iff (!rst_n)
      s_take and (translate && hit && hit_entry[`MTLB_VALID_BIT] && !hit_entry[`MTLB_WRITE_EN_BIT] && req_write
                  && !(current_user_mode_flag && req_addr < `MTLB_USER_BOUND))
      |=> resp_exc == mtlb_pkg::EXC_MODIFY && faulting_address_reg == $past(req_addr))
      else $error("write through protected entry not refused");

   a_count_range: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_ready |-> active_count >= `MTLB_MIN_ENTRIES && active_count <= `MTLB_MAX_ENTRIES)
      else $error("entry count outside four to sixty-four");

   a_highest_wins: assert property (@(posedge clk) disable iff (!rst_n)
      hit == top_hit && (!top_hit || hit_entry == table_mem[top_index]))
      else $error("lookup did not pick highest matching slot");

   a_slot_load: assert property (@(posedge clk) disable iff (!rst_n)
      tlb_wr_en && {1'b0, tlb_wr_index} < active_count
      |=> table_mem[$past(tlb_wr_index)] == {$past(entry_high_reg), $past(entry_low_reg)})
      else $error("table slot not loaded from staging registers");

endmodule

// ### mtlb_translator_tb.sv
// Self-checking bench for the address translation unit
module mtlb_translator_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
$display("ERROR %s exp %h got %h", n, e, s); end end
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] floor_select = 2'h3;
   logic [6:0] entry_count = 7'h08;
   logic [31:0] ram_base = 32'h2000_0000;
   logic [31:0] ram_size = 32'h0000_8000;
   logic reg_wr_en = 1'b0;
   logic [1:0] reg_sel = 2'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic tlb_wr_en = 1'b0;
   logic [5:0] tlb_wr_index = 6'h00;
   logic req_valid, req_write, current_user_mode_flag, resp_valid, cfg_ready;
   logic [31:0] req_addr, resp_addr, reg_rdata, floor_address;
   mtlb_pkg::mtlb_exc_e resp_exc;
   int fail_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #25 clk = ~clk;
   mtlb_core_model core (.clk(clk), .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
      .current_user_mode_flag(current_user_mode_flag));
   mtlb_translator #(.MAX_ENTRIES(64)) uut (.clk(clk), .rst_n(rst_n), .floor_select(floor_select),
      .entry_count(entry_count), .ram_base(ram_base), .ram_size(ram_size), .req_valid(req_valid),
      .req_addr(req_addr), .req_write(req_write), .current_user_mode_flag(current_user_mode_flag),
      .reg_wr_en(reg_wr_en), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .tlb_wr_en(tlb_wr_en),
      .tlb_wr_index(tlb_wr_index), .resp_valid(resp_valid), .resp_addr(resp_addr), .resp_exc(resp_exc),
      .reg_rdata(reg_rdata), .floor_address(floor_address), .cfg_ready(cfg_ready));
   task automatic close_out;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic do_reset(input logic [1:0] fl, input logic [6:0] cnt, input logic [31:0] exp_floor);
      // Callers sit on a falling edge, so reset spans exactly four cycles
      rst_n = 1'b0;
      floor_select = fl;
      entry_count = cnt;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("cfg_ready", 1'b1, cfg_ready)
      `CHK("floor_address", exp_floor, floor_address)
   endtask
   task automatic wr(input logic [1:0] s, input logic [31:0] d);
      @(negedge clk);
      reg_wr_en = 1'b1;
      reg_sel = s;
      reg_wdata = d;
      @(negedge clk);
      reg_wr_en = 1'b0;
   endtask
   task automatic rd(input logic [1:0] s, input logic [31:0] mask, input logic [31:0] e);
      @(negedge clk);
      reg_sel = s;
      @(negedge clk);
      `CHK("reg_rdata", e, reg_rdata & mask)
   endtask
   task automatic load(input logic [5:0] idx, input logic [31:0] hi, input logic [31:0] lo);
      wr(2'h0, hi);
      wr(2'h1, lo);
      tlb_wr_en = 1'b1;
      tlb_wr_index = idx;
      @(negedge clk);
      tlb_wr_en = 1'b0;
   endtask
   task automatic xl(input logic [31:0] a, input logic w, input logic u, input logic [31:0] ea,
      input mtlb_pkg::mtlb_exc_e ee);
      int n;
      n = 0;
      core.issue(a, w, u);
      while (resp_valid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      `CHK("resp_valid", 1'b1, resp_valid)
      `CHK("resp_addr", ea, resp_addr)
      `CHK("resp_exc", ee, resp_exc)
   endtask
   task automatic t_user_floor;
      do_reset(2'h3, 7'h08, 32'h8000_0000);
      wr(2'h3, 32'h0000_0000);
      rd(2'h3, 32'hffff_ffff, 32'h8000_0000);
      xl(32'h1000_0040, 1'b0, 1'b0, 32'h1000_0040, mtlb_pkg::EXC_NONE);
      xl(32'h3fff_fffc, 1'b1, 1'b1, 32'h3fff_fffc, mtlb_pkg::EXC_NONE);
      xl(32'h8000_1234, 1'b0, 1'b0, 32'h8000_1234, mtlb_pkg::EXC_REFILL);
      rd(2'h2, 32'hffff_ffff, 32'h8000_1234);
      rd(2'h0, 32'hffff_f000, 32'h8000_1000);
   endtask
   task automatic t_hits;
      load(6'h01, 32'h8000_1140, 32'h2000_1600);
      xl(32'h8000_1234, 1'b1, 1'b0, 32'h2000_1234, mtlb_pkg::EXC_NONE);
      load(6'h02, 32'h8000_2140, 32'h2000_2200);
      xl(32'h8000_2010, 1'b1, 1'b0, 32'h8000_2010, mtlb_pkg::EXC_MODIFY);
      rd(2'h2, 32'hffff_ffff, 32'h8000_2010);
      xl(32'h8000_2010, 1'b0, 1'b0, 32'h2000_2010, mtlb_pkg::EXC_NONE);
      load(6'h03, 32'h8000_3140, 32'h2000_3400);
      xl(32'h8000_3ffc, 1'b1, 1'b0, 32'h8000_3ffc, mtlb_pkg::EXC_INVALID);
      load(6'h04, 32'h8000_1140, 32'h2000_5600);
      xl(32'h8000_1234, 1'b0, 1'b0, 32'h2000_5234, mtlb_pkg::EXC_NONE);
      load(6'h09, 32'h8000_6140, 32'h2000_6600);
      xl(32'h8000_6000, 1'b0, 1'b0, 32'h8000_6000, mtlb_pkg::EXC_REFILL);
      load(6'h05, 32'h8000_7140, 32'h2000_7e00);
      xl(32'h8000_7abc, 1'b1, 1'b0, 32'h2000_7abc, mtlb_pkg::EXC_NONE);
   endtask
   task automatic t_tags;
      load(6'h06, 32'h8000_8000, 32'h2000_6700);
      wr(2'h0, 32'h8000_0180);
      xl(32'h8000_1234, 1'b0, 1'b0, 32'h8000_1234, mtlb_pkg::EXC_REFILL);
      xl(32'h8000_8abc, 1'b0, 1'b0, 32'h2000_6abc, mtlb_pkg::EXC_NONE);
   endtask
   task automatic t_phys;
      load(6'h07, 32'h8000_9180, 32'h2000_8600);
      xl(32'h8000_9004, 1'b0, 1'b0, 32'h2000_8004, mtlb_pkg::EXC_BUS_ERROR);
      load(6'h00, 32'h8000_a180, 32'h0000_1600);
      xl(32'h8000_a008, 1'b0, 1'b1, 32'h0000_1008, mtlb_pkg::EXC_ADDR_ERROR);
      xl(32'h8000_a008, 1'b0, 1'b0, 32'h0000_1008, mtlb_pkg::EXC_NONE);
   endtask
   task automatic t_floors;
      do_reset(2'h2, 7'h08, 32'h4000_0000);
      xl(32'h3fff_f000, 1'b0, 1'b0, 32'h3fff_f000, mtlb_pkg::EXC_NONE);
      xl(32'h4000_0000, 1'b0, 1'b0, 32'h4000_0000, mtlb_pkg::EXC_REFILL);
      xl(32'h4000_1000, 1'b0, 1'b1, 32'h4000_1000, mtlb_pkg::EXC_ADDR_ERROR);
      do_reset(2'h0, 7'h08, 32'hffff_ffff);
      xl(32'h8000_1234, 1'b1, 1'b1, 32'h8000_1234, mtlb_pkg::EXC_NONE);
      do_reset(2'h1, 7'h08, 32'h2000_8000);
      xl(32'h2000_7ffc, 1'b0, 1'b0, 32'h2000_7ffc, mtlb_pkg::EXC_NONE);
      xl(32'h2000_8000, 1'b0, 1'b0, 32'h2000_8000, mtlb_pkg::EXC_REFILL);
   endtask
   task automatic t_count;
      do_reset(2'h3, 7'h02, 32'h8000_0000);
      load(6'h03, 32'h8000_b000, 32'h2000_4700);
      load(6'h04, 32'h8000_c000, 32'h2000_4700);
      xl(32'h8000_b010, 1'b0, 1'b0, 32'h2000_4010, mtlb_pkg::EXC_NONE);
      xl(32'h8000_c010, 1'b0, 1'b0, 32'h8000_c010, mtlb_pkg::EXC_REFILL);
      do_reset(2'h3, 7'h7f, 32'h8000_0000);
      xl(32'h8000_b010, 1'b0, 1'b0, 32'h8000_b010, mtlb_pkg::EXC_REFILL);
      load(6'h3f, 32'h8000_d000, 32'h2000_3700);
      xl(32'h8000_d020, 1'b0, 1'b0, 32'h2000_3020, mtlb_pkg::EXC_NONE);
   endtask
   initial begin
      t_user_floor();
      t_hits();
      t_tags();
      t_phys();
      t_floors();
      t_count();
      close_out();
   end
endmodule
